// file: include/trig_timing_pkg.sv
// Constants and types shared by the camera trigger timing core
package trig_timing_pkg;
  // Clock and control tick
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W     = 7;
  // Widths
  localparam int NUM_CAMS = 4;
  localparam int TIMER_W  = 20;
  localparam int FLASH_W  = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int DIAG_W   = 8;
  localparam int SEL_W    = 3;
  localparam int SRC_N    = 8;
  localparam int DST_N    = 7;
  // Register offsets
  localparam logic [7:0] ADDR_CSR          = 8'h00;
  localparam logic [7:0] ADDR_CAM_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_UNIT_CTRL    = 8'h02;
  localparam logic [7:0] ADDR_FRAME_PERIOD = 8'h03;
  localparam logic [7:0] ADDR_CAM_COUNT0   = 8'h04;
  localparam logic [7:0] ADDR_CAM_COUNT3   = 8'h07;
  localparam logic [7:0] ADDR_FLASH_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_FLASH_TIMING = 8'h09;
  localparam logic [7:0] ADDR_STATUS       = 8'h0A;
  localparam logic [7:0] ADDR_VERSION      = 8'hFF;
  // Field positions
  localparam int CSR_ENABLE_BIT    = 0;
  localparam int CSR_BUSY_CLR_BIT  = 1;
  localparam int CAM_EN_LSB        = 0;
  localparam int CAM_TRIG_LSB      = 4;
  localparam int UNIT_COMPRESS_BIT = 0;
  localparam int FLASH_DUR_LSB     = 0;
  localparam int FLASH_DELAY_LSB   = 16;
  // Reset values
  localparam logic [19:0] RST_FRAME_PERIOD = 20'hF4240;
  localparam logic [19:0] RST_CAM_COUNT    = 20'h00000;
  localparam logic [31:0] RST_FLASH_TIMING = 32'h0000_0064;
  // Arbitrary version value
  localparam logic [31:0] VERSION_VALUE    = 32'h0000_0101;
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_DELAY = 2'b01,
    FL_ON    = 2'b10
  } flash_state_t;
endpackage : trig_timing_pkg

// file: rtl/flash_timer.sv
// Per-camera LED flash delay and duration timer
`timescale 1ns/10ps
module flash_timer (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Timing control
  input  wire logic                                tick,
  input  wire logic                                start,
  input  wire logic                                allow,
  input  wire logic [trig_timing_pkg::FLASH_W-1:0] delay,
  input  wire logic [trig_timing_pkg::FLASH_W-1:0] duration,
  // Flash enable
  output logic                                     flash
);
  import trig_timing_pkg::*;

  flash_state_t         state_ff;
  flash_state_t         nxt_state;
  logic [FLASH_W-1:0]   cnt_ff;
  logic [FLASH_W-1:0]   nxt_cnt;
  logic                 flash_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (!allow) begin
      nxt_state = FL_IDLE;
    end else if (start) begin
      if (delay != '0) begin
        nxt_state = FL_DELAY;
        nxt_cnt   = delay;
      end else if (duration != '0) begin
        nxt_state = FL_ON;
        nxt_cnt   = duration;
      end else begin
        nxt_state = FL_IDLE;
      end
    end else if (tick) begin
      unique case (state_ff)
        FL_IDLE: nxt_state = FL_IDLE;
        FL_DELAY: begin
          if (cnt_ff == FLASH_W'(1)) begin
            nxt_state = (duration != '0) ? FL_ON : FL_IDLE;
            nxt_cnt   = duration;
          end else begin
            nxt_cnt = cnt_ff - FLASH_W'(1);
          end
        end
        FL_ON: begin
          if (cnt_ff == FLASH_W'(1)) begin
            nxt_state = FL_IDLE;
          end else begin
            nxt_cnt = cnt_ff - FLASH_W'(1);
          end
        end
        default: nxt_state = FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= FL_IDLE;
      cnt_ff   <= '0;
      flash_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      flash_ff <= (nxt_state == FL_ON);
    end
  end

  assign flash = flash_ff;

  AST_FLASH_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    !allow |=> !flash) else $error("flash on while blocked");
endmodule : flash_timer

// file: rtl/frame_trigger_core.sv
// Frame timer, camera strobes, flash, trigger fan-out and registers
//
// Contract
// - Frame logic advances on a one-microsecond control tick.
// - Frame period in microseconds comes from a host-written register.
// - Frame timer starts at zero, counts each microsecond, wraps at period.
// - Camera strobe fires when the timer equals its acquire count.
// - Acquire count above the period never strobes that camera.
// - One shared frame rate; each camera's point placed independently.
// - 32-bit flash timing holds delay and duration in microseconds.
// - Flash enable rises after the delay following the camera strobe.
// - Flash enable stays on for the duration, then drops.
// - Triggers align to the control tick, output the next cycle.
// - Fanned-out triggers last exactly one control cycle.
// - Camera, host, sensor, external sources feed all destinations.
// - Busy drives both the sensor unit and the general busy output.
// - Compress relay energised normally, released to request compress.
// - A time base output feeds the sensor scope.
// - Free run triggers cameras alone; host activity overrides it.
// - Selector chooses one of eight diagnostic sets for test points.
// - Busy sets on any trigger event, clears on busy clear bit.
// - Global enable low holds all camera and flash outputs inactive unless free run is active.
// - Camera enable low holds that camera's strobe and flash inactive unless free run is active.
// - Frame strobe lasts one microsecond at the matching count.
`timescale 1ns/10ps
module frame_trigger_core (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Register port
  input  wire logic [trig_timing_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [trig_timing_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic [trig_timing_pkg::DATA_W-1:0]       reg_rdata,
  // Front panel and host path
  input  wire logic                                free_run_sw,
  input  wire logic                                host_cmd_active,
  input  wire logic [trig_timing_pkg::SEL_W-1:0]   diagnostic_set_selector,
  // Trigger sources
  input  wire logic [trig_timing_pkg::NUM_CAMS-1:0] trig_cam_in,
  input  wire logic                                trig_host_in,
  input  wire logic                                trig_sensor_in,
  input  wire logic                                trig_ext_in,
  // Camera and flash outputs
  output logic [trig_timing_pkg::NUM_CAMS-1:0]     frame_strobe,
  output logic [trig_timing_pkg::NUM_CAMS-1:0]     flash_enable,
  // Trigger destinations
  output logic [trig_timing_pkg::NUM_CAMS-1:0]     trig_cam_out,
  output logic                                     trig_host_out,
  output logic                                     trig_plc_out,
  output logic                                     trig_ext_out,
  // Status outputs
  output logic                                     busy_sensor_out,
  output logic                                     busy_out,
  output logic                                     compress_relay_on,
  output logic                                     time_base,
  output logic                                     free_run_led,
  output logic [trig_timing_pkg::DIAG_W-1:0]       diag_out
);
  import trig_timing_pkg::*;

  // Registers
  logic                 global_en_ff;
  logic [NUM_CAMS-1:0]  cam_en_ff;
  logic [NUM_CAMS-1:0]  flash_allow_ff;
  logic                 compress_req_ff;
  logic [TIMER_W-1:0]   period_ff;
  logic [TIMER_W-1:0]   acq_ff [NUM_CAMS];
  logic [DATA_W-1:0]    flash_timing_ff;
  logic [DATA_W-1:0]    rdata_ff;
  // Timing state
  logic [TICK_CNT_W-1:0] tick_cnt_ff;
  logic                  tick;
  logic [TIMER_W-1:0]    timer_ff;
  logic [NUM_CAMS-1:0]   strobe_ff;
  logic [NUM_CAMS-1:0]   flash_w;
  logic                  time_base_ff;
  // Control and trigger state
  logic                  busy_ff;
  logic                  override_ff;
  logic [NUM_CAMS-1:0]   manual_trig_ff;
  logic [DIAG_W-1:0]     diag_ff;
  logic                  free_active;
  logic                  eff_global;
  logic [NUM_CAMS-1:0]   eff_cam;
  logic                  period_wr;
  logic                  busy_clr;
  logic                  trig_event;
  logic                  trig_w;
  logic [SRC_N-1:0]      trig_src;
  logic [FLASH_W-1:0]    flash_delay;
  logic [FLASH_W-1:0]    flash_dur;

  assign period_wr   = reg_wr && (reg_addr == ADDR_FRAME_PERIOD);
  assign busy_clr    = reg_wr && (reg_addr == ADDR_CSR)
                       && reg_wdata[CSR_BUSY_CLR_BIT];
  assign flash_delay = flash_timing_ff[FLASH_DELAY_LSB +: FLASH_W];
  assign flash_dur   = flash_timing_ff[FLASH_DUR_LSB +: FLASH_W];

  // Free run gives full enable until the host speaks on either path
  assign free_active = free_run_sw & ~override_ff;
  assign eff_global  = global_en_ff | free_active;
  assign eff_cam     = free_active ? {NUM_CAMS{1'b1}} : cam_en_ff;

  // One-microsecond control tick from the fast clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_CNT_W'(1);
    end
  end
  assign tick = (tick_cnt_ff == TICK_CNT_W'(TICK_CYCLES - 1));

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_en_ff    <= 1'b0;
      cam_en_ff       <= '0;
      flash_allow_ff  <= {NUM_CAMS{1'b1}};
      compress_req_ff <= 1'b0;
      period_ff       <= RST_FRAME_PERIOD;
      flash_timing_ff <= RST_FLASH_TIMING;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CSR:          global_en_ff <= reg_wdata[CSR_ENABLE_BIT];
        ADDR_CAM_CTRL:     cam_en_ff <= reg_wdata[CAM_EN_LSB +: NUM_CAMS];
        ADDR_UNIT_CTRL:    compress_req_ff <= reg_wdata[UNIT_COMPRESS_BIT];
        ADDR_FRAME_PERIOD: period_ff <= reg_wdata[TIMER_W-1:0];
        ADDR_FLASH_CTRL:   flash_allow_ff <= reg_wdata[NUM_CAMS-1:0];
        ADDR_FLASH_TIMING: flash_timing_ff <= reg_wdata;
        default:           ;
      endcase
    end
  end

  // Acquire counts, one register per camera
  generate
    for (genvar i = 0; i < NUM_CAMS; i++) begin : g_cam
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          acq_ff[i] <= RST_CAM_COUNT;
        end else if (reg_wr && reg_addr == ADDR_CAM_COUNT0 + 8'(i)) begin
          acq_ff[i] <= reg_wdata[TIMER_W-1:0];
        end
      end

      // Equality to a timer that never passes the period keeps
      // out-of-range counts silent
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          strobe_ff[i] <= 1'b0;
        end else if (!eff_global || !eff_cam[i]) begin
          strobe_ff[i] <= 1'b0;
        end else if (tick) begin
          strobe_ff[i] <= (timer_ff == acq_ff[i]);
        end
      end

      flash_timer u_flash (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .start    (tick && eff_global && eff_cam[i]
                   && timer_ff == acq_ff[i]),
        .allow    (eff_global && eff_cam[i] && flash_allow_ff[i]),
        .delay    (flash_delay),
        .duration (flash_dur),
        .flash    (flash_w[i])
      );

      AST_STROBE_RANGE: assert property (@(posedge clk)
        disable iff (!rst_n)
        tick && acq_ff[i] > period_ff && timer_ff <= period_ff
        |=> !strobe_ff[i]) else $error("strobe beyond period");
    end
  endgenerate

  // Shared frame timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_ff <= '0;
    end else if (period_wr) begin
      timer_ff <= '0;
    end else if (tick) begin
      if (timer_ff >= period_ff) begin
        timer_ff <= '0;
      end else begin
        timer_ff <= timer_ff + TIMER_W'(1);
      end
    end
  end

  // Square time base for the sensor scope
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      time_base_ff <= 1'b0;
    end else if (tick) begin
      time_base_ff <= ~time_base_ff;
    end
  end

  // Host takeover of free run, released when the switch is turned off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      override_ff <= 1'b0;
    end else if (!free_run_sw) begin
      override_ff <= 1'b0;
    end else if (reg_wr || host_cmd_active) begin
      override_ff <= 1'b1;
    end
  end

  // Manual triggers held one write's worth so the edge detector sees them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      manual_trig_ff <= '0;
    end else if (reg_wr && reg_addr == ADDR_CAM_CTRL) begin
      manual_trig_ff <= reg_wdata[CAM_TRIG_LSB +: NUM_CAMS];
    end else begin
      manual_trig_ff <= '0;
    end
  end

  assign trig_src = {|manual_trig_ff, trig_ext_in, trig_sensor_in,
                     trig_host_in, trig_cam_in};

  trigger_fanout u_fanout (
    .clk         (clk),
    .rst_n       (rst_n),
    .tick        (tick),
    .src         (trig_src),
    .event_pulse (trig_event),
    .trig_out    (trig_w)
  );

  // Busy: a trigger arriving with the clear still sets it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (trig_event) begin
      busy_ff <= 1'b1;
    end else if (busy_clr) begin
      busy_ff <= 1'b0;
    end
  end

  // Diagnostic sets for the test points
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      diag_ff <= '0;
    end else begin
      unique case (diagnostic_set_selector)
        3'h0: diag_ff <= {flash_w, strobe_ff};
        3'h1: diag_ff <= trig_src;
        3'h2: diag_ff <= timer_ff[7:0];
        3'h3: diag_ff <= timer_ff[15:8];
        3'h4: diag_ff <= {4'h0, timer_ff[19:16]};
        3'h5: diag_ff <= {tick, time_base_ff, trig_w, busy_ff,
                          compress_req_ff, free_active, override_ff,
                          eff_global};
        3'h6: diag_ff <= {eff_cam, cam_en_ff};
        3'h7: diag_ff <= {flash_allow_ff, manual_trig_ff};
      endcase
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      if (reg_addr >= ADDR_CAM_COUNT0 && reg_addr <= ADDR_CAM_COUNT3) begin
        rdata_ff <= {12'h000, acq_ff[reg_addr[1:0]]};
      end else begin
        unique case (reg_addr)
          ADDR_CSR:          rdata_ff <= {31'h0, global_en_ff};
          ADDR_CAM_CTRL:     rdata_ff <= {28'h0, cam_en_ff};
          ADDR_UNIT_CTRL:    rdata_ff <= {31'h0, compress_req_ff};
          ADDR_FRAME_PERIOD: rdata_ff <= {12'h000, period_ff};
          ADDR_FLASH_CTRL:   rdata_ff <= {28'h0, flash_allow_ff};
          ADDR_FLASH_TIMING: rdata_ff <= flash_timing_ff;
          ADDR_STATUS:       rdata_ff <= {4'h0, free_active, busy_ff,
                                          flash_w, timer_ff, 2'h0};
          ADDR_VERSION:      rdata_ff <= VERSION_VALUE;
          default:           rdata_ff <= '0;
        endcase
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata         = rdata_ff;
  assign frame_strobe      = strobe_ff;
  assign flash_enable      = flash_w;
  assign trig_cam_out      = {NUM_CAMS{trig_w}};
  assign trig_host_out     = trig_w;
  assign trig_plc_out      = trig_w;
  assign trig_ext_out      = trig_w;
  assign busy_sensor_out   = busy_ff;
  assign busy_out          = busy_ff;
  assign compress_relay_on = ~compress_req_ff;
  assign time_base         = time_base_ff;
  assign free_run_led      = free_active;
  assign diag_out          = diag_ff;

  AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick [*8]) else $error("tick too frequent");
  AST_TIMER_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !period_wr && timer_ff == period_ff |=> timer_ff == '0)
    else $error("timer did not wrap");
  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !period_wr && timer_ff < period_ff
    |=> timer_ff == $past(timer_ff) + TIMER_W'(1))
    else $error("timer did not step");
  AST_PERIOD_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    period_wr |=> timer_ff == '0) else $error("no restart");
  AST_STROBE_HIT: assert property (@(posedge clk) disable iff (!rst_n)
    tick && eff_global && eff_cam[0] && timer_ff == acq_ff[0]
    ##1 eff_global && eff_cam[0] |-> strobe_ff[0])
    else $error("strobe missed");
  AST_STROBE_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    !eff_global |=> strobe_ff == '0) else $error("strobe while off");
  AST_BUSY_SET: assert property (@(posedge clk) disable iff (!rst_n)
    trig_event |=> busy_out && busy_sensor_out)
    else $error("busy not set");
  AST_BUSY_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    busy_clr && !trig_event |=> !busy_out) else $error("busy stuck");
  AST_RELAY: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_UNIT_CTRL && reg_wdata[UNIT_COMPRESS_BIT]
    |=> !compress_relay_on) else $error("relay not released");
endmodule : frame_trigger_core

// file: rtl/trigger_fanout.sv
// Trigger capture, control clock alignment and fan-out pulse
`timescale 1ns/10ps
module trigger_fanout (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // Control tick and sources
  input  wire logic                              tick,
  input  wire logic [trig_timing_pkg::SRC_N-1:0] src,
  // Results
  output logic                                   event_pulse,
  output logic                                   trig_out
);
  import trig_timing_pkg::*;

  logic [SRC_N-1:0] src_q_ff;
  logic             pend_ff;
  logic             sync_ff;
  logic             out_ff;
  logic             rise_any;

  assign rise_any = |(src & ~src_q_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q_ff <= '0;
    end else begin
      src_q_ff <= src;
    end
  end

  // New edge wins over the tick that consumes the older one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= rise_any | (pend_ff & ~tick);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_ff <= 1'b0;
      out_ff  <= 1'b0;
    end else if (tick) begin
      sync_ff <= pend_ff;
      out_ff  <= sync_ff;
    end
  end

  assign event_pulse = tick & sync_ff;
  assign trig_out    = out_ff;

  AST_FANOUT_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
    tick && sync_ff |=> trig_out) else $error("trigger not fanned out");
  AST_FANOUT_EDGES: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(trig_out) |-> $past(tick)) else $error("pulse off tick");
endmodule : trigger_fanout

// file: verification/tb_frame_trigger_core.sv
// Self-checking bench for the camera trigger timing core
`timescale 1ns/10ps
module tb_frame_trigger_core;
  import trig_timing_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        wr = 1'b0, rd = 1'b0, fire = 1'b0, ext;
  logic [2:0]  sel = 3'h0;
  logic [3:0]  fs, fl, tco, seen;
  logic [3:0]  cin = 4'h0;
  logic [7:0]  dg;
  logic        tho, tpo, teo, bso, bo, relay, tbase, frl;
  logic        frs = 1'b0, hc = 1'b0;
  int          rises, mismatches = 0, n_compared = 0, n;
  wire  [10:0] mon = {tbase, bo, teo, fl, fs};
  always #5 clk = ~clk;
  frame_trigger_core u_frame_trigger_core (.clk(clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .free_run_sw(frs), .host_cmd_active(hc),
    .diagnostic_set_selector(sel), .trig_cam_in(cin),
    .trig_host_in(1'b0), .trig_sensor_in(1'b0), .trig_ext_in(ext),
    .frame_strobe(fs), .flash_enable(fl), .trig_cam_out(tco),
    .trig_host_out(tho), .trig_plc_out(tpo), .trig_ext_out(teo),
    .busy_sensor_out(bso), .busy_out(bo), .compress_relay_on(relay),
    .time_base(tbase), .free_run_led(frl), .diag_out(dg));
  trig_far_side u_trig_far_side (.clk(clk), .rst_n(rst_n), .fire(fire),
    .frame_strobe(fs), .trig_ext_in(ext), .seen(seen), .rises(rises));
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_chk
  // Cycles until monitored bit i shows v; bounded
  task wait_for(input int i, input logic v);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (n > 2000) begin
        mismatches++;
        summarize();
      end
    end while (mon[i] !== v);
  endtask : wait_for
  task t_reset_values;
    check(relay, 1'b1);
    rd_chk(ADDR_FRAME_PERIOD, 32'h000F_4240);
    rd_chk(ADDR_FLASH_TIMING, RST_FLASH_TIMING);
    rd_chk(8'h20, 32'h0);
    wr_reg(ADDR_FLASH_TIMING, 32'h0002_0003);
    rd_chk(ADDR_FLASH_TIMING, 32'h0002_0003);
  endtask : t_reset_values
  task t_frame_flash;
    wr_reg(ADDR_FRAME_PERIOD, 32'h5);
    wr_reg(8'h05, 32'h3);
    wr_reg(8'h06, 32'h6);
    wr_reg(ADDR_CAM_CTRL, 32'h7);
    wr_reg(ADDR_CSR, 32'h1);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check(n, 100);
    wait_for(1, 1'b1);
    check(n, 200);
    wait_for(0, 1'b1);
    check(n, 300);
    wait_for(4, 1'b1);
    check(n, 200);
    wait_for(4, 1'b0);
    check(n, 300);
    wait_for(0, 1'b1);
    check(n, 100);
    check(seen[3:2], 2'b00);
  endtask : t_frame_flash
  task t_trigger_busy;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_for(8, 1'b1);
    check(n > 99 && n < 203, 1'b1);
    check({tco, tho, tpo}, 6'h3F);
    wait_for(8, 1'b0);
    check(n, 100);
    check({bo, bso}, 2'b11);
    wr_reg(ADDR_CSR, 32'h3);
    @(posedge clk);
    #1 check(bo, 1'b0);
    wr_reg(ADDR_UNIT_CTRL, 32'h1);
    #1 check(relay, 1'b0);
    wr_reg(ADDR_UNIT_CTRL, 32'h0);
  endtask : t_trigger_busy
  task t_disable;
    int r;
    wr_reg(ADDR_CSR, 32'h0);
    r = rises;
    repeat (800) @(posedge clk);
    check(rises, r);
    wr_reg(ADDR_CSR, 32'h1);
    wr_reg(ADDR_CAM_CTRL, 32'h6);
    r = rises;
    repeat (800) @(posedge clk);
    check(rises, r);
    check(fl[0], 1'b0);
  endtask : t_disable
  task t_sources;
    @(posedge clk);
    cin <= 4'h2;
    @(posedge clk);
    cin <= 4'h0;
    wait_for(8, 1'b1);
    check(tco, 4'hF);
    check({bo, bso}, 2'b11);
    wait_for(8, 1'b0);
    wr_reg(ADDR_CAM_CTRL, 32'h16);
    wait_for(8, 1'b1);
    check({tho, tpo}, 2'b11);
    wait_for(8, 1'b0);
  endtask : t_sources
  task t_panel;
    @(posedge clk);
    sel <= 3'h6;
    repeat (2) @(posedge clk);
    #1 check(dg, 8'h66);
    @(posedge clk);
    sel <= 3'h7;
    repeat (2) @(posedge clk);
    #1 check(dg, 8'hF0);
    wait_for(10, ~mon[10]);
    wait_for(10, ~mon[10]);
    check(n, 100);
    // Free run must strobe with global enable off, until host speaks
    wr_reg(ADDR_CSR, 32'h0);
    @(posedge clk);
    frs <= 1'b1;
    wait_for(0, 1'b1);
    check({frl, n < 601}, 2'b11);
    @(posedge clk);
    hc <= 1'b1;
    @(posedge clk);
    hc <= 1'b0;
    @(posedge clk);
    #1 check({frl, fs}, 5'h00);
    @(posedge clk);
    frs <= 1'b0;
  endtask : t_panel
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_frame_flash();
    t_trigger_busy();
    t_disable();
    t_sources();
    t_panel();
    summarize();
  end
endmodule : tb_frame_trigger_core

// file: verification/trig_far_side.sv
// Far-side model: external trigger source and watching cameras
`timescale 1ns/10ps
module trig_far_side (
  // Clock and command
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fire,
  // Camera side
  input  wire logic [3:0] frame_strobe,
  output logic            trig_ext_in,
  output logic [3:0]      seen,
  output int              rises
);
  logic [3:0] prev_ff;
  int         hold;
  initial begin
    trig_ext_in = 1'b0;
    seen = 4'h0;
    rises = 0;
    hold = 0;
    prev_ff = 4'h0;
  end
  // A real source bounces no less than this: held several cycles
  always @(posedge clk) begin
    hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
    trig_ext_in <= fire || (hold > 1);
    prev_ff <= frame_strobe;
    // Strobes are unknown until the core's first reset edge
    seen <= rst_n ? (seen | frame_strobe) : 4'h0;
    if (frame_strobe[0] && !prev_ff[0]) begin
      rises <= rises + 1;
    end
  end
endmodule : trig_far_side
